// [logic/ege_engine.sv]
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
module ege_engine
    import ege_pkg::*;
#(
    parameter int NUM_AXES = AXES_DEF,
    parameter int NUM_POINTS = POINTS_DEF,
    parameter int ENGAGE_CYCLES = ENGAGE_CYC,
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    input wire logic [NUM_AXES-1:0][31:0] axis_pos,
    input wire logic emergency_stop_input_n,
    output logic master_halt,
    output logic cmd_busy,
    output logic [NUM_AXES-1:0] slave_engaged,
    output logic [NUM_AXES-1:0][31:0] slave_cmd_pos,
    output logic [NUM_AXES-1:0][15:0] slave_table_index
);
    localparam int IW = $clog2(NUM_POINTS + 1);
    localparam int AW = (NUM_AXES > 1) ? $clog2(NUM_AXES) : 1;

    typedef struct packed {
        ege_fsm_t fsm;
        logic [AW-1:0] slv;
        logic [15:0] tick_cnt;
        logic [15:0] busy_cnt;
        logic es1;
        logic es2;
        logic halt_master;
        logic refused;
        logic [NUM_AXES-1:0] master_mask;
        logic [NUM_AXES-1:0] slave_mask;
        logic [NUM_AXES-1:0] engaged;
        logic [NUM_AXES-1:0] armed;
        logic [NUM_AXES-1:0] ramping;
        logic [31:0] max_accel;
        logic [IW-1:0] pt_start;
        logic [IW-1:0] pt_index;
        logic [31:0] pt_mpos;
        logic [31:0] pt_spos;
        logic [31:0] mprev;
        logic [NUM_AXES-1:0][IW-1:0] tstart;
        logic [NUM_AXES-1:0][IW-1:0] tsize;
        logic [NUM_AXES-1:0][IW-1:0] tidx;
        logic [NUM_AXES-1:0][31:0] trig;
        logic [NUM_AXES-1:0][31:0] mref;
        logic [NUM_AXES-1:0][31:0] sbase;
        logic [NUM_AXES-1:0][31:0] spos;
        logic [NUM_AXES-1:0][31:0] svel;
        logic [31:0] rdata;
        ege_point_t [NUM_POINTS-1:0] pts;
    } ege_state_t;

    ege_state_t st;
    ege_state_t next_st;

    // ==================================================================
    // helpers
    function automatic logic [IW-1:0] ege_addr(input logic [IW-1:0] base,
                                               input logic [IW-1:0] off);
        logic [IW:0] s;
        s = {1'b0, base} + {1'b0, off};
        // out-of-range tables clip instead of aliasing other tables
        if (s > (IW+1)'(NUM_POINTS - 1)) begin
            s = (IW+1)'(NUM_POINTS - 1);
        end
        return s[IW-1:0];
    endfunction : ege_addr

    function automatic logic [AW-1:0] ege_onehot(input logic [NUM_AXES-1:0] m);
        logic [AW-1:0] r;
        r = '0;
        for (int i = 0; i < NUM_AXES; i++) begin
            if (m[i]) begin
                r = AW'(i);
            end
        end
        return r;
    endfunction : ege_onehot

    function automatic logic [31:0] ege_interp(input ege_point_t p0, input ege_point_t p1,
                                               input logic [31:0] t);
        logic signed [31:0] dm;
        logic signed [63:0] num;
        logic signed [63:0] q;
        dm = $signed(p1.mpos) - $signed(p0.mpos);
        num = 64'($signed($signed(p1.spos) - $signed(p0.spos)))
            * 64'($signed($signed(t) - $signed(p0.mpos)));
        q = (dm == 32'sh0000_0000) ? 64'sh0000_0000_0000_0000 : num / 64'(dm);
        return q[31:0];
    endfunction : ege_interp

    function automatic logic [31:0] ege_clamp(input logic [31:0] dv, input logic [31:0] lim);
        if ($signed(dv) > $signed(lim)) begin
            return lim;
        end else if ($signed(dv) < -$signed(lim)) begin
            return -lim;
        end
        return dv;
    endfunction : ege_clamp

    // ==================================================================
    // combinational view of the slave under work
    logic [AW-1:0] msel;
    logic [31:0] mpos;
    logic [AW-1:0] k;
    logic [IW-1:0] last;
    logic [31:0] travel;
    ege_point_t p_cur;
    ege_point_t p_nxt;
    ege_point_t p_last;
    logic [31:0] target;
    logic [31:0] want_vel;
    logic [31:0] new_vel;
    logic tick;
    logic cmd_ok;

    always_comb begin
        msel = ege_onehot(st.master_mask);
        mpos = axis_pos[msel];
        k = st.slv;
        last = st.tsize[k] - IW'(1);
        travel = mpos - st.mref[k];
        p_cur = st.pts[ege_addr(st.tstart[k], st.tidx[k])];
        p_nxt = st.pts[ege_addr(st.tstart[k], st.tidx[k] + IW'(1))];
        p_last = st.pts[ege_addr(st.tstart[k], last)];
        target = st.sbase[k] + p_cur.spos + ege_interp(p_cur, p_nxt, travel);
        // a halted or ramping slave aims at zero speed instead of the table
        want_vel = (st.halt_master || st.ramping[k]) ? 32'h0000_0000 : target - st.spos[k];
        new_vel = st.svel[k] + ege_clamp(want_vel - st.svel[k], st.max_accel);
        tick = (st.tick_cnt == 16'(TICK_CYCLES - 1));
        cmd_ok = wr_en && (addr == REG_CMD) && (st.busy_cnt == 16'h0000);
    end

    // ==================================================================
    // next state
    always_comb begin
        next_st = st;
        next_st.es1 = ~emergency_stop_input_n;
        next_st.es2 = st.es1;
        next_st.halt_master = st.es2;
        next_st.rdata = 32'h0000_0000;
        next_st.tick_cnt = tick ? 16'h0000 : st.tick_cnt + 16'h0001;
        if (st.busy_cnt != 16'h0000) begin
            next_st.busy_cnt = st.busy_cnt - 16'h0001;
        end
        case (st.fsm)
            EGE_IDLE: begin
                if (tick) begin
                    next_st.slv = '0;
                    next_st.fsm = EGE_SEEK;
                    next_st.mprev = mpos;
                    for (int i = 0; i < NUM_AXES; i++) begin
                        // crossing check so a fast master cannot skip the trigger
                        if (st.armed[i] && ((mpos == st.trig[i])
                            || (($signed(mpos - st.trig[i]) < 0)
                                != ($signed(st.mprev - st.trig[i]) < 0)))) begin
                            next_st.armed[i] = 1'b0;
                            next_st.engaged[i] = 1'b1;
                            next_st.mref[i] = st.trig[i];
                            next_st.sbase[i] = st.spos[i];
                            next_st.tidx[i] = '0;
                        end
                    end
                end
            end
            EGE_SEEK: begin
                if (!st.engaged[k]) begin
                    next_st.fsm = (k == AW'(NUM_AXES - 1)) ? EGE_IDLE : EGE_SEEK;
                    next_st.slv = k + AW'(1);
                end else if (st.tidx[k] >= last) begin
                    next_st.mref[k] = st.mref[k] + p_last.mpos;
                    next_st.sbase[k] = st.sbase[k] + p_last.spos;
                    next_st.tidx[k] = '0;
                end else if ($signed(travel) >= $signed(p_nxt.mpos)) begin
                    next_st.tidx[k] = st.tidx[k] + IW'(1);
                end else if ($signed(travel) < $signed(p_cur.mpos)) begin
                    if (st.tidx[k] == '0) begin
                        next_st.mref[k] = st.mref[k] - p_last.mpos;
                        next_st.sbase[k] = st.sbase[k] - p_last.spos;
                        next_st.tidx[k] = last - IW'(1);
                    end else begin
                        next_st.tidx[k] = st.tidx[k] - IW'(1);
                    end
                end else begin
                    next_st.fsm = EGE_STEP;
                end
            end
            EGE_STEP: begin
                next_st.svel[k] = new_vel;
                next_st.spos[k] = st.spos[k] + new_vel;
                if (st.ramping[k] && new_vel == 32'h0000_0000) begin
                    next_st.ramping[k] = 1'b0;
                    next_st.engaged[k] = 1'b0;
                end
                next_st.fsm = (k == AW'(NUM_AXES - 1)) ? EGE_IDLE : EGE_SEEK;
                next_st.slv = k + AW'(1);
            end
            default: begin
                next_st.fsm = EGE_IDLE;
            end
        endcase

        // register writes
        if (wr_en) begin
            if (addr == REG_CMD) begin
                next_st.refused = !cmd_ok;
                if (cmd_ok) begin
                    if (wdata[7:0] == CMD_ENGAGE) begin
                        next_st.busy_cnt = 16'(ENGAGE_CYCLES);
                        for (int i = 0; i < NUM_AXES; i++) begin
                            if (st.slave_mask[i]) begin
                                next_st.engaged[i] = 1'b1;
                                next_st.armed[i] = 1'b0;
                                next_st.ramping[i] = 1'b0;
                                next_st.mref[i] = mpos;
                                next_st.sbase[i] = st.spos[i];
                                next_st.tidx[i] = '0;
                            end
                        end
                    end else if (wdata[7:0] == CMD_ENGAGE_POS) begin
                        next_st.busy_cnt = 16'(ENGAGE_CYCLES);
                        next_st.armed = next_st.armed | (st.slave_mask & ~next_st.engaged);
                    end else if (wdata[7:0] == CMD_OFF) begin
                        next_st.busy_cnt = 16'(OFF_CYC);
                        next_st.engaged = next_st.engaged & ~st.slave_mask;
                        next_st.armed = next_st.armed & ~st.slave_mask;
                        next_st.ramping = next_st.ramping & ~st.slave_mask;
                        for (int i = 0; i < NUM_AXES; i++) begin
                            if (st.slave_mask[i]) begin
                                next_st.svel[i] = 32'h0000_0000;
                            end
                        end
                    end else if (wdata[7:0] == CMD_OFF_RAMP) begin
                        next_st.busy_cnt = 16'(RAMP_OFF_CYC);
                        next_st.ramping = next_st.ramping | (st.slave_mask & next_st.engaged);
                        next_st.armed = next_st.armed & ~st.slave_mask;
                    end else if (wdata[7:0] == CMD_POINT) begin
                        next_st.busy_cnt = 16'(POINT_CYC);
                        next_st.pts[ege_addr(st.pt_start, st.pt_index)] = {st.pt_mpos, st.pt_spos};
                    end else begin
                        next_st.refused = 1'b1;
                    end
                end
            end else if (addr == REG_MASTER_MASK) begin
                next_st.master_mask = wdata[NUM_AXES-1:0];
            end else if (addr == REG_SLAVE_MASK) begin
                next_st.slave_mask = wdata[NUM_AXES-1:0];
            end else if (addr == REG_MAX_ACCEL) begin
                next_st.max_accel = wdata;
            end else if (addr == REG_PT_START) begin
                next_st.pt_start = wdata[IW-1:0];
            end else if (addr == REG_PT_INDEX) begin
                next_st.pt_index = wdata[IW-1:0];
            end else if (addr == REG_PT_MPOS) begin
                next_st.pt_mpos = wdata;
            end else if (addr == REG_PT_SPOS) begin
                next_st.pt_spos = wdata;
            end else if (addr >= REG_AXIS_BASE && addr < REG_AXIS_BASE + 8'(NUM_AXES * 16)) begin
                if (addr[3:2] == AX_START) begin
                    next_st.tstart[AW'((addr - REG_AXIS_BASE) >> 4)] = wdata[IW-1:0];
                end else if (addr[3:2] == AX_SIZE) begin
                    next_st.tsize[AW'((addr - REG_AXIS_BASE) >> 4)] = wdata[IW-1:0];
                end else if (addr[3:2] == AX_TRIG) begin
                    next_st.trig[AW'((addr - REG_AXIS_BASE) >> 4)] = wdata;
                end
            end
        end

        // register reads, answer stands in the following cycle only
        if (rd_en) begin
            if (addr == REG_MASTER_MASK) begin
                next_st.rdata = 32'(st.master_mask);
            end else if (addr == REG_SLAVE_MASK) begin
                next_st.rdata = 32'(st.slave_mask);
            end else if (addr == REG_MAX_ACCEL) begin
                next_st.rdata = st.max_accel;
            end else if (addr == REG_STATUS) begin
                next_st.rdata[ST_BUSY] = (st.busy_cnt != 16'h0000);
                next_st.rdata[ST_EMERGENCY_STOP_INPUT] = st.es2;
                next_st.rdata[ST_HALT] = st.halt_master;
                next_st.rdata[ST_REFUSED] = st.refused;
            end else if (addr == REG_ENGAGED) begin
                next_st.rdata = 32'(st.engaged);
            end else if (addr >= REG_AXIS_BASE && addr < REG_AXIS_BASE + 8'(NUM_AXES * 16)) begin
                if (addr[3:2] == AX_START) begin
                    next_st.rdata = 32'(st.tstart[AW'((addr - REG_AXIS_BASE) >> 4)]);
                end else if (addr[3:2] == AX_SIZE) begin
                    next_st.rdata = 32'(st.tsize[AW'((addr - REG_AXIS_BASE) >> 4)]);
                end else if (addr[3:2] == AX_TRIG) begin
                    next_st.rdata = st.trig[AW'((addr - REG_AXIS_BASE) >> 4)];
                end else begin
                    next_st.rdata = 32'(st.tidx[AW'((addr - REG_AXIS_BASE) >> 4)]);
                end
            end else if (addr >= REG_POS_BASE && addr < REG_POS_BASE + 8'(NUM_AXES * 4)) begin
                next_st.rdata = st.spos[AW'((addr - REG_POS_BASE) >> 2)];
            end
        end
    end

    // ==================================================================
    // state register; ce low freezes everything
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign master_halt = st.halt_master;
    assign cmd_busy = (st.busy_cnt != 16'h0000);
    assign slave_engaged = st.engaged;
    assign slave_cmd_pos = st.spos;
    always_comb begin
        for (int i = 0; i < NUM_AXES; i++) begin
            slave_table_index[i] = 16'(st.tidx[i]);
        end
    end

    // ==================================================================
    // checks
    AST_INDEX_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
        st.engaged[k] && st.tsize[k] >= IW'(3) |-> st.tidx[k] < st.tsize[k])
        else $error("table index beyond table end");
    AST_WRAP_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        ce && st.fsm == EGE_SEEK && st.engaged[k] && st.tidx[k] >= last && !wr_en
        |=> st.tidx[$past(k)] == '0)
        else $error("index did not wrap to zero at cycle end");
    AST_ACCEL_CAP: assert property (@(posedge clk) disable iff (!rst_n)
        ce && st.fsm == EGE_STEP && !wr_en
        |=> $signed(st.svel[$past(k)] - $past(st.svel[k])) <= $signed($past(st.max_accel))
            && $signed($past(st.svel[k]) - st.svel[$past(k)]) <= $signed($past(st.max_accel)))
        else $error("slave velocity change exceeds accel limit");
    AST_EMERGENCY_STOP_INPUT_HALT: assert property (@(posedge clk) disable iff (!rst_n)
        ce && st.es2 |=> master_halt)
        else $error("master not halted on emergency stop");
    AST_EMERGENCY_STOP_INPUT_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
        ce && st.halt_master && !wr_en
        |=> ($past(st.engaged) & ~$past(st.ramping) & ~st.engaged) == '0)
        else $error("slave released by emergency stop");
    AST_ENGAGE_NOW: assert property (@(posedge clk) disable iff (!rst_n)
        ce && cmd_ok && wdata[7:0] == CMD_ENGAGE
        |=> (st.engaged & $past(st.slave_mask)) == $past(st.slave_mask) && cmd_busy)
        else $error("immediate engage did not engage masked slaves");
    AST_OFF_DONE: assert property (@(posedge clk) disable iff (!rst_n)
        ce && cmd_ok && wdata[7:0] == CMD_OFF
        |=> (st.engaged & $past(st.slave_mask)) == '0 ##[1:250] !cmd_busy)
        else $error("immediate disengage late or incomplete");
    AST_RAMP_START: assert property (@(posedge clk) disable iff (!rst_n)
        ce && cmd_ok && wdata[7:0] == CMD_OFF_RAMP
        |=> (st.ramping & $past(st.slave_mask & st.engaged)) == $past(st.slave_mask & st.engaged))
        else $error("ramped disengage did not start");
    AST_POINT_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        ce && cmd_ok && wdata[7:0] == CMD_POINT
        |=> st.pts[ege_addr($past(st.pt_start), $past(st.pt_index))]
            == {$past(st.pt_mpos), $past(st.pt_spos)})
        else $error("point not stored");
endmodule : ege_engine

// [logic/ege_pkg.sv]
package ege_pkg;
    // ==================================================================
    // clock and execution times
    localparam int CLK_KHZ = 25000;
    localparam int ENGAGE_US = 200;
    localparam int OFF_US = 10;
    localparam int RAMP_OFF_US = 50;
    localparam int POINT_US = 200;
    localparam int TICK_US = 200;
    localparam int ENGAGE_CYC = ENGAGE_US * CLK_KHZ / 1000;
    localparam int OFF_CYC = OFF_US * CLK_KHZ / 1000;
    localparam int RAMP_OFF_CYC = RAMP_OFF_US * CLK_KHZ / 1000;
    localparam int POINT_CYC = POINT_US * CLK_KHZ / 1000;
    localparam int TICK_CYC = TICK_US * CLK_KHZ / 1000;

    // ==================================================================
    // sizes
    localparam int AXES_DEF = 4;
    localparam int POINTS_DEF = 1600;

    // ==================================================================
    // command codes
    localparam logic [7:0] CMD_ENGAGE = 8'hA4;
    localparam logic [7:0] CMD_ENGAGE_POS = 8'hA5;
    localparam logic [7:0] CMD_OFF = 8'hA7;
    localparam logic [7:0] CMD_OFF_RAMP = 8'hA8;
    localparam logic [7:0] CMD_POINT = 8'hB3;

    // ==================================================================
    // register offsets (byte addresses)
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_MASTER_MASK = 8'h04;
    localparam logic [7:0] REG_SLAVE_MASK = 8'h08;
    localparam logic [7:0] REG_MAX_ACCEL = 8'h0C;
    localparam logic [7:0] REG_PT_START = 8'h10;
    localparam logic [7:0] REG_PT_INDEX = 8'h14;
    localparam logic [7:0] REG_PT_MPOS = 8'h18;
    localparam logic [7:0] REG_PT_SPOS = 8'h1C;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam logic [7:0] REG_ENGAGED = 8'h24;
    localparam logic [7:0] REG_AXIS_BASE = 8'h40;
    localparam logic [7:0] REG_POS_BASE = 8'hC0;
    localparam logic [1:0] AX_START = 2'h0;
    localparam logic [1:0] AX_SIZE = 2'h1;
    localparam logic [1:0] AX_TRIG = 2'h2;
    localparam logic [1:0] AX_INDEX = 2'h3;

    // status bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_EMERGENCY_STOP_INPUT = 1;
    localparam int ST_HALT = 2;
    localparam int ST_REFUSED = 3;

    typedef enum logic [1:0] {
        EGE_IDLE = 2'b00,
        EGE_SEEK = 2'b01,
        EGE_STEP = 2'b10
    } ege_fsm_t;

    typedef struct packed {
        logic [31:0] mpos;
        logic [31:0] spos;
    } ege_point_t;
endpackage : ege_pkg

// [test/ege_host.sv]
`timescale 1ns/1ps
// ======================================
// commanding host: register bus master
module ege_host (
    input wire logic clk,
    input wire logic [31:0] rdata,
    output logic [7:0] addr,
    output logic [31:0] wdata,
    output logic wr_en,
    output logic rd_en
);
    initial begin
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        wdata <= ~d; // stale data never looks valid
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata; // stands for one cycle only
    endtask : rd
endmodule : ege_host

// [test/tb_ege_engine.sv]
`timescale 1ns/1ps
module tb_ege_engine;
    import ege_pkg::*;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    localparam logic [31:0] ONE = 32'h0000_0001;
    localparam logic [31:0] AX1 = 32'h0000_0002;
    logic clk;
    logic rst_n;
    logic stop_n;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr_en;
    logic rd_en;
    logic [31:0] rdata;
    logic [3:0][31:0] axis_pos;
    logic halt;
    logic busy;
    logic [3:0] eng;
    logic [3:0][31:0] spos;
    logic [3:0][15:0] sidx;
    logic [31:0] r;
    int n_errors = 0;
    int tests_run = 0;
    int n;
    int mt[4] = '{25, 50, 75, 125};
    int st[4] = '{10, 20, 30, 50};
    int it[4] = '{0, 1, 1, 0};
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    ege_host u_ege_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en));
    // short tick and engage time keep the run brief
    ege_engine #(.ENGAGE_CYCLES(10), .TICK_CYCLES(20)) u_ege_engine (.clk(clk),
        .rst_n(rst_n), .ce(1'b1), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .axis_pos(axis_pos),
        .emergency_stop_input_n(stop_n), .master_halt(halt), .cmd_busy(busy),
        .slave_engaged(eng), .slave_cmd_pos(spos), .slave_table_index(sidx));
    // ======================================
    // helpers
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic step(input int k);
        repeat (k) begin
            @(posedge clk);
            #1;
        end
    endtask : step
    task automatic cmd(input logic [7:0] code, input int cyc);
        u_ege_host.wr(REG_CMD, {24'h00_0000, code});
        #1;
        n = 0;
        while (busy !== 1'b1 && n < 4) begin
            step(1);
            n++;
        end
        n = 0;
        while (busy === 1'b1 && n < 20000) begin
            step(1);
            n++;
        end
        // one cycle of slack for where the busy edge lands
        check("busy span", 32'(n >= cyc - 1 && n <= cyc + 1), ONE);
    endtask : cmd
    task automatic point(input int i, input int mp, input int sp);
        u_ege_host.wr(REG_PT_START, ZERO);
        u_ege_host.wr(REG_PT_INDEX, 32'(i));
        u_ege_host.wr(REG_PT_MPOS, 32'(mp));
        u_ege_host.wr(REG_PT_SPOS, 32'(sp));
        cmd(CMD_POINT, 5000);
    endtask : point
    task automatic print_verdict;
        if (n_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    // ======================================
    // watchdog
    initial begin
        #(40 * 40000);
        n_errors++;
        print_verdict();
    end
    // ======================================
    // tests
    initial begin
        rst_n = 1'b0;
        stop_n = 1'b1;
        axis_pos = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        step(1);
        check("reset outputs", 32'({halt, busy, eng, sidx[1]}), ZERO);
        u_ege_host.rd(8'h30, r);
        check("unmapped read", r, ZERO);
        u_ege_host.wr(REG_CMD, 32'h0000_00FF);
        u_ege_host.rd(REG_STATUS, r);
        check("refused status", r, 32'h0000_0008);
        point(0, 0, 0);
        point(1, 50, 20);
        point(2, 100, 40);
        u_ege_host.wr(REG_MAX_ACCEL, 32'h0000_4000);
        u_ege_host.wr(8'h50, ZERO);
        u_ege_host.wr(8'h54, 32'h0000_0003);
        u_ege_host.wr(REG_MASTER_MASK, ONE);
        u_ege_host.wr(REG_SLAVE_MASK, AX1);
        cmd(CMD_ENGAGE, 10);
        check("engaged", 32'(eng), AX1);
        // last step crosses the cycle end and wraps to entry zero
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            axis_pos[0] <= 32'(mt[k]);
            step(100);
            check("slave pos", spos[1], 32'(st[k]));
            u_ege_host.rd(8'h5C, r);
            check("table index", r, 32'(it[k]));
            check("index out", 32'(sidx[1]), 32'(it[k]));
        end
        u_ege_host.rd(8'hC4, r);
        check("pos register", r, 32'h0000_0032);
        @(posedge clk);
        stop_n <= 1'b0;
        step(2);
        check("halt early", 32'(halt), ZERO);
        step(2);
        check("halt", 32'(halt), ONE);
        step(100);
        check("engaged in stop", 32'(eng), AX1);
        u_ege_host.rd(REG_ENGAGED, r);
        check("engaged register", r, AX1);
        u_ege_host.rd(REG_STATUS, r);
        check("stop status", r, 32'h0000_0006);
        @(posedge clk);
        stop_n <= 1'b1;
        step(4);
        check("halt released", 32'(halt), ZERO);
        cmd(CMD_OFF, 250);
        check("released", 32'(eng), ZERO);
        u_ege_host.wr(8'h58, 32'h0000_00C8);
        cmd(CMD_ENGAGE_POS, 10);
        step(60);
        check("armed only", 32'(eng), ZERO);
        @(posedge clk);
        axis_pos[0] <= 32'h0000_00C8;
        step(60);
        check("trigger engage", 32'(eng), AX1);
        cmd(CMD_OFF_RAMP, 1250);
        step(100);
        check("ramp release", 32'(eng), ZERO);
        print_verdict();
    end
endmodule : tb_ege_engine
